//--- slr_host.sv
// host model of the register port: one-cycle strobes launched at falling clock edges
// assumes the device answers a read one cycle after the strobe edge
module slr_host (
    input  wire logic       clk_in,
    output logic            wr_en_out,
    output logic            rd_en_out,
    output logic      [6:0] addr_out,
    output logic      [7:0] wdata_out,
    output logic      [7:0] pd_field_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle port; power-down field cleared for a working configuration
    initial begin
        {wr_en_out, rd_en_out, addr_out, wdata_out} = 17'h00000;
        pd_field_out = 8'h00;
    end
    // only all zero or all one: a partial field would leave the part half powered down
    task automatic set_pd(input logic all_down);
        @(negedge clk_in) pd_field_out = all_down ? 8'hff : 8'h00;
    endtask
    // address and data stay put after the strobe drops, so no stale-looking request can form
    task automatic acc(input logic w, input logic [6:0] a, input logic [7:0] d);
        @(negedge clk_in) {wr_en_out, rd_en_out, addr_out, wdata_out} = {w, !w, a, d};
        @(negedge clk_in) {wr_en_out, rd_en_out} = 2'b00;
    endtask
endmodule

//--- slr_pkg.sv
// package for the signal-loss status register tail of the crosspoint switch map
// assumes an 8-bit register port with 7-bit addresses driven by a serial-port front end
package slr_pkg;
    localparam logic [6:0] ADDR_CTRL     = 7'h25;  // readback-select and update bits
    localparam logic [6:0] ADDR_SPARE    = 7'h26;
    localparam logic [6:0] ADDR_LOSS_01  = 7'h27;
    localparam logic [6:0] ADDR_LOSS_23  = 7'h28;
    localparam int         BIT_READBACK  = 6;
    localparam int         BIT_UPDATE    = 7;
    localparam logic [7:0] RST_CTRL      = 8'h20;  // spare bit 5 resets to one
    localparam logic [7:0] RST_SPARE     = 8'h55;
    localparam logic [7:0] RST_POWERDOWN = 8'h00;
    localparam logic [15:0] RST_LOSS     = 16'h0000;
    localparam int         LANES         = 16;
endpackage

//--- slr_regs.sv
// signal-loss status registers with control register 0x25, spare 0x26 and bank power-down field
// assumes a serial-port front end gives one-cycle write and read strobes on clk_in
// assumes the lane detectors are asynchronous levels and the power-down field comes from clk_in logic
module slr_regs (
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    input  wire logic        wr_en_in,
    input  wire logic        rd_en_in,
    input  wire logic [6:0]  addr_in,
    input  wire logic [7:0]  wdata_in,
    input  wire logic [15:0] lane_loss_in,
    input  wire logic [7:0]  bank_power_down_field_in,
    output logic      [7:0]  rdata_out,
    output logic             rvalid_out,
    output logic      [7:0]  active_power_down_out,
    output logic      [7:0]  active_ctrl_out,
    output logic      [7:0]  active_spare_out
);
    // pairs of _q and _d below, one always_comb and one always_ff per group of state

    // synchronised loss flags, bit 4*bank+lane, each bit driven by its own lane slice
    wire logic [slr_pkg::LANES-1:0] loss_flags;

    // per-bank views of the flags; two banks share one status byte
    logic      [3:0]                lane_signal_loss_bank0;
    logic      [3:0]                lane_signal_loss_bank1;
    logic      [3:0]                lane_signal_loss_bank2;
    logic      [3:0]                lane_signal_loss_bank3;

    // stored copies, written by the host and shown when readback-select is one
    logic      [7:0]                ctrl_q;
    logic      [7:0]                ctrl_d;
    logic      [7:0]                spare_q;
    logic      [7:0]                spare_d;

    // active copies, the bits that really drive the analog controls
    logic      [7:0]                act_ctrl_q;
    logic      [7:0]                act_ctrl_d;
    logic      [7:0]                act_spare_q;
    logic      [7:0]                act_spare_d;
    logic      [7:0]                act_pd_q;
    logic      [7:0]                act_pd_d;

    // read port state
    logic      [7:0]                read_mux;
    logic      [7:0]                rdata_q;
    logic      [7:0]                rdata_d;
    logic                           rvalid_q;
    logic                           rvalid_d;

    // decoded write strobes and the readback selector
    logic                           wr_ctrl;
    logic                           wr_spare;
    logic                           do_update;
    logic                           readback_stored;
    logic      [7:0]                update_clear_mask;

    // lane synchronisers: the detectors are analog and free running, so each flag
    // passes two flip-flops and only the second one ever feeds the read mux
    generate
        for (genvar lane = 0; lane < slr_pkg::LANES; lane = lane + 1) begin : g_lane_sync
            // two stages per lane; the bank is lane / 4 and the lane within it lane % 4
            logic meta_q;
            logic meta_d;
            logic flag_q;
            logic flag_d;

            // next values: the first stage samples the pin, the second the first
            always_comb begin
                meta_d = lane_loss_in[lane];
                flag_d = meta_q;
            end

            // the reset branch loads constants only, so a detector glitch in reset is ignored
            always_ff @(posedge clk_in or posedge rst_in) begin
                if (rst_in) begin
                    meta_q <= slr_pkg::RST_LOSS[lane];
                    flag_q <= slr_pkg::RST_LOSS[lane];
                end else begin
                    meta_q <= meta_d;
                    flag_q <= flag_d;
                end
            end

            assign loss_flags[lane] = flag_q;
        end
    endgenerate

    // bank slices: lanes 0..3 of each bank sit in four neighbouring bits
    assign lane_signal_loss_bank0 = loss_flags[3:0];
    assign lane_signal_loss_bank1 = loss_flags[7:4];
    assign lane_signal_loss_bank2 = loss_flags[11:8];
    assign lane_signal_loss_bank3 = loss_flags[15:12];
    // limitation: a detector pulse shorter than one clock period may never be seen, the flags
    // show the level at sampling time and do not latch a loss that has already gone away

    // write decode; writes to the loss addresses or unmapped ones match nothing and are dropped
    assign wr_ctrl           = wr_en_in && (addr_in == slr_pkg::ADDR_CTRL);
    assign wr_spare          = wr_en_in && (addr_in == slr_pkg::ADDR_SPARE);
    assign do_update         = wr_ctrl && wdata_in[slr_pkg::BIT_UPDATE];
    // the readback selector is taken from the stored copy so it acts at once
    assign readback_stored   = ctrl_q[slr_pkg::BIT_READBACK];
    // the update bit is never stored, so it cannot fire a second time on its own
    assign update_clear_mask = ~(8'h01 << slr_pkg::BIT_UPDATE);

    // trade-off: the host writes stored copies freely and nothing reaches the analog side until
    // an update, so a half-written set of controls never shows up on the active outputs
    // stored group: next values
    always_comb begin
        ctrl_d  = ctrl_q;
        spare_d = spare_q;
        if (wr_ctrl) begin
            ctrl_d = wdata_in & update_clear_mask;
        end
        if (wr_spare) begin
            spare_d = wdata_in;
        end
    end

    // stored group: registers, loaded with their initial values by reset
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            ctrl_q  <= slr_pkg::RST_CTRL;
            spare_q <= slr_pkg::RST_SPARE;
        end else begin
            ctrl_q  <= ctrl_d;
            spare_q <= spare_d;
        end
    end

    // the bank power-down field lives outside this block; it is copied here only on update,
    // and the host keeps it all zero unless the whole part is being powered down
    // active group: next values; an update takes the control bits of the same write,
    // so readback-select and update written together both take effect at once
    always_comb begin
        act_ctrl_d  = act_ctrl_q;
        act_spare_d = act_spare_q;
        act_pd_d    = act_pd_q;
        if (do_update) begin
            act_ctrl_d  = ctrl_d;
            act_spare_d = spare_d;
            act_pd_d    = bank_power_down_field_in;  // a one shuts its bank down
        end
    end

    // active group: registers; every bit is active high, so reset leaves the functions as
    // the initial values describe them
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            act_ctrl_q  <= slr_pkg::RST_CTRL;
            act_spare_q <= slr_pkg::RST_SPARE;
            act_pd_q    <= slr_pkg::RST_POWERDOWN;
        end else begin
            act_ctrl_q  <= act_ctrl_d;
            act_spare_q <= act_spare_d;
            act_pd_q    <= act_pd_d;
        end
    end

    // read mux; readback-select chooses stored or active copies, the loss bytes are always live
    always_comb begin
        read_mux = 8'h00;
        unique case (addr_in)
            slr_pkg::ADDR_CTRL: begin
                read_mux = (readback_stored ? ctrl_q : act_ctrl_q) & update_clear_mask;
            end
            slr_pkg::ADDR_SPARE: begin
                read_mux = readback_stored ? spare_q : act_spare_q;
            end
            slr_pkg::ADDR_LOSS_01: begin
                read_mux = {lane_signal_loss_bank1, lane_signal_loss_bank0};
            end
            slr_pkg::ADDR_LOSS_23: begin
                read_mux = {lane_signal_loss_bank3, lane_signal_loss_bank2};
            end
            default: begin
                read_mux = 8'h00;  // unmapped addresses read as zero
            end
        endcase
    end

    // hazard: the loss bytes can change between the strobe and the answer, the value returned
    // is the one the synchroniser held at the strobe edge
    // read port: next values; the data holds between reads so a slow host can still pick it up
    always_comb begin
        rdata_d  = rdata_q;
        rvalid_d = rd_en_in;
        if (rd_en_in) begin
            rdata_d = read_mux;
        end
    end

    // read port: registers; the answer comes exactly one cycle after the strobe
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            rdata_q  <= 8'h00;
            rvalid_q <= 1'b0;
        end else begin
            rdata_q  <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    // outputs come straight from flip-flops
    // so nothing downstream sees a glitch from the decode
    assign rdata_out             = rdata_q;
    assign rvalid_out            = rvalid_q;
    assign active_power_down_out = act_pd_q;
    assign active_ctrl_out       = act_ctrl_q;
    assign active_spare_out      = act_spare_q;
endmodule

//--- slr_regs_sva.sv
// assertions on the slr_regs ports; one clock, reset high
// assumes it is bound into slr_regs and sees only that module's ports
module slr_regs_sva (
    input wire logic        clk_in,
    input wire logic        rst_in,
    input wire logic        wr_en_in,
    input wire logic        rd_en_in,
    input wire logic [6:0]  addr_in,
    input wire logic [7:0]  wdata_in,
    input wire logic [15:0] lane_loss_in,
    input wire logic [7:0]  bank_power_down_field_in,
    input wire logic [7:0]  rdata_out,
    input wire logic        rvalid_out,
    input wire logic [7:0]  active_power_down_out,
    input wire logic [7:0]  active_ctrl_out,
    input wire logic [7:0]  active_spare_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    // read strobes per address and the update strobe
    wire rd_low  = rd_en_in && (addr_in == 7'h27);
    wire rd_high = rd_en_in && (addr_in == 7'h28);
    wire upd     = wr_en_in && (addr_in == 7'h25) && wdata_in[7];
    // loss reads need four stable samples so the two-stage synchroniser has caught up
    chk_loss_low: assert property ($stable(lane_loss_in)[*4] ##0 rd_low
        |=> rdata_out == $past(lane_loss_in[7:0])) else $error("loss low byte wrong");
    chk_loss_high: assert property ($stable(lane_loss_in)[*4] ##0 rd_high
        |=> rdata_out == $past(lane_loss_in[15:8])) else $error("loss high byte wrong");
    chk_read_valid: assert property (rvalid_out == $past(rd_en_in))
        else $error("read valid not one cycle after strobe");
    chk_update_copy: assert property (upd |=> active_ctrl_out == ($past(wdata_in) & 8'h7f))
        else $error("update did not copy control bits");
    chk_pd_copy: assert property (upd |=> active_power_down_out == $past(bank_power_down_field_in))
        else $error("update did not copy power-down field");
    chk_active_hold: assert property (!upd |=>
        $stable(active_ctrl_out) && $stable(active_power_down_out) && $stable(active_spare_out))
        else $error("active bits changed without update");
    chk_ctrl_msb: assert property (rd_en_in && (addr_in == 7'h25) |=> !rdata_out[7])
        else $error("update bit read as one");
    chk_unmapped_zero: assert property (rd_en_in && (addr_in > 7'h28) |=> rdata_out == 8'h00)
        else $error("unmapped read not zero");
endmodule
bind slr_regs slr_regs_sva u_slr_regs_sva (.*);

//--- slr_regs_test.sv
// bench: host model drives the register port, bench drives the lane detectors
// assumes slr_pkg, slr_regs, slr_host and the bound checker are compiled first
module slr_regs_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_in = 1'b0;
    logic        rst_in = 1'b1;
    logic        wr_en_in;
    logic        rd_en_in;
    logic        rvalid_out;
    logic [6:0]  addr_in;
    logic [7:0]  wdata_in;
    logic [7:0]  bank_power_down_field_in;
    logic [7:0]  rdata_out;
    logic [7:0]  active_power_down_out;
    logic [7:0]  active_ctrl_out;
    logic [7:0]  active_spare_out;
    logic [15:0] lane_loss_in = 16'h0000;
    int          miscompares = 0;
    int          n_tests = 0;
    int          cycles = 0;
    slr_host u_slr_host (
        .clk_in       (clk_in),
        .wr_en_out    (wr_en_in),
        .rd_en_out    (rd_en_in),
        .addr_out     (addr_in),
        .wdata_out    (wdata_in),
        .pd_field_out (bank_power_down_field_in)
    );
    slr_regs u_slr_regs (
        .clk_in                   (clk_in),
        .rst_in                   (rst_in),
        .wr_en_in                 (wr_en_in),
        .rd_en_in                 (rd_en_in),
        .addr_in                  (addr_in),
        .wdata_in                 (wdata_in),
        .lane_loss_in             (lane_loss_in),
        .bank_power_down_field_in (bank_power_down_field_in),
        .rdata_out                (rdata_out),
        .rvalid_out               (rvalid_out),
        .active_power_down_out    (active_power_down_out),
        .active_ctrl_out          (active_ctrl_out),
        .active_spare_out         (active_spare_out)
    );
    // 4 ns clock; ceiling far above the sixty-odd cycles the sequence needs
    always #2 clk_in = ~clk_in;
    always @(posedge clk_in) if (++cycles == 1000) begin miscompares++; stop_test(); end
    task automatic cmp(input string what, input logic [23:0] exp, got);
        n_tests++;
        if (got !== exp) begin miscompares++; $display("mismatch %s expected %h seen %h", what, exp, got); end
    endtask
    task automatic act(input logic [23:0] e); cmp("active", e, {active_ctrl_out, active_spare_out, active_power_down_out});
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        u_slr_host.acc(1'b0, a, 8'h00);
        cmp("read", {15'h0000, 1'b1, e}, {15'h0000, rvalid_out, rdata_out});
    endtask
    task automatic stop_test();
        $display("comparisons %0d miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // reset values, live loss flags, ignored writes, stored versus active readback, update copy
    initial begin
        repeat (10) @(posedge clk_in);
        @(negedge clk_in) rst_in = 1'b0;
        act(24'h205500);
        rd(7'h27, 8'h00);
        rd(7'h28, 8'h00);
        lane_loss_in = 16'ha5c3;
        repeat (3) @(negedge clk_in);
        rd(7'h27, 8'hc3);
        rd(7'h28, 8'ha5);
        u_slr_host.acc(1'b1, 7'h27, 8'hff);
        u_slr_host.acc(1'b1, 7'h28, 8'hff);
        rd(7'h27, 8'hc3);
        rd(7'h28, 8'ha5);
        lane_loss_in = 16'h0000;
        repeat (3) @(negedge clk_in);
        rd(7'h27, 8'h00);
        rd(7'h28, 8'h00);
        u_slr_host.acc(1'b1, 7'h25, 8'hc0);
        rd(7'h25, 8'h40);
        act(24'h405500);
        u_slr_host.acc(1'b1, 7'h26, 8'h3c);
        rd(7'h26, 8'h3c);
        u_slr_host.acc(1'b1, 7'h25, 8'h00);
        rd(7'h26, 8'h55);
        rd(7'h25, 8'h40);
        u_slr_host.set_pd(1'b1);
        u_slr_host.acc(1'b1, 7'h25, 8'h80);
        act(24'h003cff);
        u_slr_host.set_pd(1'b0);
        u_slr_host.acc(1'b1, 7'h25, 8'h80);
        act(24'h003c00);
        rd(7'h7f, 8'h00);
        // second reset in mid-run brings back the initial stored and active values
        @(negedge clk_in) rst_in = 1'b1;
        repeat (2) @(negedge clk_in);
        rst_in = 1'b0;
        act(24'h205500);
        rd(7'h25, 8'h20);
        rd(7'h26, 8'h55);
        stop_test();
    end
endmodule
